// ---- rtl/dsg_ctrl.sv ----
`timescale 1ns/100ps
// deep-sleep port clock gating and software reset controls
module dsg_ctrl #(
    parameter int NUM_PORTS = dsg_pkg::NUM_PORTS
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // register port
    input  wire logic [11:0]          reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // system state inputs
    input  wire logic [1:0]           power_state,
    input  wire logic                 auto_clock_gating,
    input  wire logic [NUM_PORTS-1:0] run_port_clock_gate,
    input  wire logic [NUM_PORTS-1:0] sleep_port_clock_gate,
    input  wire logic [31:0]          capability_mask_first,
    // port access monitor
    input  wire logic [NUM_PORTS-1:0] port_access,
    output logic      [NUM_PORTS-1:0] port_clk_en,
    output logic      [NUM_PORTS-1:0] port_bus_fault,
    // unit resets
    output logic                      conv_reset,
    output logic                      watchdog_reset_ctrl
);

    //------------------------------------------------------------------------
    // register state
    //------------------------------------------------------------------------
    logic [NUM_PORTS-1:0] gate_reg;     // deep-sleep gating bits
    logic [NUM_PORTS-1:0] gate_next;
    logic [31:0]          srst_reg;     // software reset register
    logic [31:0]          srst_next;
    logic [31:0]          rdata_reg;    // read data, one cycle late
    logic [31:0]          rdata_next;

    // address decode shared by read and write paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // write path: masked writes into implemented bits only
    always_comb begin
        gate_next = gate_reg;
        srst_next = srst_reg;
        if (reg_wr && hit(reg_addr, dsg_pkg::ADDR_DEEP_SLEEP_GATE)) begin
            // bits 31:5 are dropped
            gate_next = reg_wdata[NUM_PORTS-1:0];
        end
        if (reg_wr && hit(reg_addr, dsg_pkg::ADDR_SOFT_RESET_CTRL_FIRST)) begin
            // absent units keep their old value
            srst_next = (srst_reg & ~capability_mask_first)
                      | (reg_wdata & capability_mask_first
                         & dsg_pkg::SRST_WRITE_MASK);
            srst_next = srst_next & dsg_pkg::SRST_WRITE_MASK;
        end
    end

    // read path: unmapped addresses read zero
    always_comb begin
        rdata_next = dsg_pkg::READ_ZERO;
        if (reg_rd) begin
            if (hit(reg_addr, dsg_pkg::ADDR_DEEP_SLEEP_GATE)) begin
                rdata_next = {{(32-NUM_PORTS){1'b0}}, gate_reg};
            end else if (hit(reg_addr, dsg_pkg::ADDR_SOFT_RESET_CTRL_FIRST)) begin
                rdata_next = srst_reg;
            end else begin
                rdata_next = dsg_pkg::READ_ZERO;
            end
        end
    end

    //------------------------------------------------------------------------
    // register update
    //------------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gate_reg  <= dsg_pkg::GATE_RST_VAL[NUM_PORTS-1:0];
            srst_reg  <= dsg_pkg::SOFT_RESET_RST_VAL;
            rdata_reg <= dsg_pkg::READ_ZERO;
        end else begin
            gate_reg  <= gate_next;
            srst_reg  <= srst_next;
            rdata_reg <= rdata_next;
        end
    end

    //------------------------------------------------------------------------
    // gate selection and fault detection
    //------------------------------------------------------------------------
    logic [NUM_PORTS-1:0] gate_sel;     // mask in force now
    logic [NUM_PORTS-1:0] fault_comb;   // access hitting a gated port

    dsg_port_gate #(
        .NUM_PORTS                  (NUM_PORTS)
    ) u_gate (
        .power_state                (power_state),
        .auto_clock_gating          (auto_clock_gating),
        .run_port_clock_gate        (run_port_clock_gate),
        .sleep_port_clock_gate      (sleep_port_clock_gate),
        .deep_sleep_port_clock_gate (gate_reg),
        .port_access                (port_access),
        .gate_en                    (gate_sel),
        .access_fault               (fault_comb)
    );

    //------------------------------------------------------------------------
    // registered outputs
    //------------------------------------------------------------------------
    // one cycle of latency keeps every output straight from a flop
    logic [NUM_PORTS-1:0] clk_en_reg;
    logic [NUM_PORTS-1:0] clk_en_next;
    logic [NUM_PORTS-1:0] fault_reg;
    logic [NUM_PORTS-1:0] fault_next;
    logic                 conv_rst_reg;
    logic                 conv_rst_next;
    logic                 wdog_rst_reg;
    logic                 wdog_rst_next;

    always_comb begin
        clk_en_next   = gate_sel;
        fault_next    = fault_comb;
        conv_rst_next = srst_next[dsg_pkg::BIT_CONV_RESET];
        wdog_rst_next = srst_next[dsg_pkg::BIT_WDOG_RESET];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clk_en_reg   <= '0;
            fault_reg    <= '0;
            conv_rst_reg <= 1'b0;
            wdog_rst_reg <= 1'b0;
        end else begin
            clk_en_reg   <= clk_en_next;
            fault_reg    <= fault_next;
            conv_rst_reg <= conv_rst_next;
            wdog_rst_reg <= wdog_rst_next;
        end
    end

    assign reg_rdata           = rdata_reg;
    assign port_clk_en         = clk_en_reg;
    assign port_bus_fault      = fault_reg;
    assign conv_reset          = conv_rst_reg;
    assign watchdog_reset_ctrl = wdog_rst_reg;

endmodule : dsg_ctrl

// ---- include/dsg_pkg.sv ----
//----------------------------------------------------------------------------
// deep-sleep port clock gating and software reset: shared constants
//----------------------------------------------------------------------------
// Summary of operation
// - deep sleep: set bit clocks port, clear stops
// - access to gated port answers bus fault
// - deep-sleep gate bits reset to zero
// - power state picks run, sleep or deep mask
// - sleep masks used only with auto gating set
// - one gate bit per port, E=4 down A=0
// - gate bits 31:5 read zero, ignore writes
// - reset register writes masked by capability bits
// - bit 16 resets converter module 0
// - bit 3 resets the watchdog unit
// - reset register reads zero after reset
// - reset register bits 31:17,15:4,2:0 read zero
package dsg_pkg;

    //------------------------------------------------------------------------
    // register map (byte addresses)
    //------------------------------------------------------------------------
    localparam logic [11:0] ADDR_SOFT_RESET_CTRL_FIRST = 12'h040;
    localparam logic [11:0] ADDR_DEEP_SLEEP_GATE       = 12'h128;

    //------------------------------------------------------------------------
    // field layout and reset values
    //------------------------------------------------------------------------
    localparam int          NUM_PORTS          = 5;
    localparam int          BIT_CONV_RESET     = 16;
    localparam int          BIT_WDOG_RESET     = 3;
    localparam logic [31:0] GATE_WRITE_MASK    = 32'h0000_001F;
    localparam logic [31:0] SRST_WRITE_MASK    = 32'h0001_0008;
    localparam logic [31:0] SOFT_RESET_RST_VAL = 32'h0000_0000;
    localparam logic [4:0]  GATE_RST_VAL       = 5'h00;
    localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

    // power states of the core
    typedef enum logic [1:0] {
        DSG_RUN,
        DSG_SLEEP,
        DSG_DEEP
    } dsg_power_t;

endpackage : dsg_pkg

// ---- rtl/dsg_port_gate.sv ----
`timescale 1ns/100ps
// per-port gate selection and fault check
module dsg_port_gate #(
    parameter int NUM_PORTS = 5
) (
    input  wire logic [1:0]           power_state,
    input  wire logic                 auto_clock_gating,
    input  wire logic [NUM_PORTS-1:0] run_port_clock_gate,
    input  wire logic [NUM_PORTS-1:0] sleep_port_clock_gate,
    input  wire logic [NUM_PORTS-1:0] deep_sleep_port_clock_gate,
    input  wire logic [NUM_PORTS-1:0] port_access,
    output logic      [NUM_PORTS-1:0] gate_en,
    output logic      [NUM_PORTS-1:0] access_fault
);

    //------------------------------------------------------------------------
    // mask selection by power state
    //------------------------------------------------------------------------
    // without auto gating, sleep states keep the run mask
    always_comb begin
        case (power_state)
            dsg_pkg::DSG_SLEEP: begin
                gate_en = auto_clock_gating ? sleep_port_clock_gate
                                            : run_port_clock_gate;
            end
            dsg_pkg::DSG_DEEP: begin
                gate_en = auto_clock_gating ? deep_sleep_port_clock_gate
                                            : run_port_clock_gate;
            end
            default: begin
                gate_en = run_port_clock_gate;
            end
        endcase
    end

    //------------------------------------------------------------------------
    // fault on access to an unclocked port
    //------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_fault
            assign access_fault[g] = port_access[g] & ~gate_en[g];
        end
    endgenerate

endmodule : dsg_port_gate

// ---- dv/dsg_ctrl_assertions.sv ----
`timescale 1ns/100ps
//--------------------------------
// gating and soft reset checker
//--------------------------------
module dsg_ctrl_chk #(
    parameter int NUM_PORTS = dsg_pkg::NUM_PORTS
) (
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire logic [11:0]          reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    input wire logic [1:0]           power_state,
    input wire logic                 auto_clock_gating,
    input wire logic [NUM_PORTS-1:0] run_port_clock_gate,
    input wire logic [NUM_PORTS-1:0] sleep_port_clock_gate,
    input wire logic [31:0]          capability_mask_first,
    input wire logic [NUM_PORTS-1:0] port_access,
    input wire logic [NUM_PORTS-1:0] port_clk_en,
    input wire logic [NUM_PORTS-1:0] port_bus_fault,
    input wire logic                 conv_reset,
    input wire logic                 watchdog_reset_ctrl
);
    logic [NUM_PORTS-1:0] shd_reg;  // copy of stored deep mask
    logic [NUM_PORTS-1:0] sel_mask; // mask due now
    logic [1:0]           srst_exp; // reset bits after write
    logic                 srst_hit; // write to reset register
    assign srst_hit = reg_wr && (reg_addr == dsg_pkg::ADDR_SOFT_RESET_CTRL_FIRST);
    // capability 0 keeps old value
    assign srst_exp = {capability_mask_first[16] ? reg_wdata[16] : conv_reset,
                       capability_mask_first[3] ? reg_wdata[3] : watchdog_reset_ctrl};
    // no auto gating: run mask everywhere
    assign sel_mask = !auto_clock_gating ? run_port_clock_gate :
                      (power_state == 2'h1) ? sleep_port_clock_gate :
                      (power_state == 2'h2) ? shd_reg : run_port_clock_gate;
    // shadow fed from bus writes
    always_ff @(posedge clock) begin
        if (!rst_n)
            shd_reg <= '0;
        else if (reg_wr && (reg_addr == dsg_pkg::ADDR_DEEP_SLEEP_GATE))
            shd_reg <= reg_wdata[NUM_PORTS-1:0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // sampled rst_n in the antecedent: the release edge itself is not checked
    a_mask_select: assert property (rst_n |=> port_clk_en == $past(sel_mask))
        else $error("enable mismatch");
    a_fault_gated: assert property (rst_n |=>
        port_bus_fault == ($past(port_access) & ~$past(sel_mask)))
        else $error("fault mismatch");
    a_rd_idle: assert property (!reg_rd |=> reg_rdata == dsg_pkg::READ_ZERO)
        else $error("stray read data");
    a_gate_read: assert property (reg_rd && reg_addr == 12'h128 |=>
        reg_rdata == 32'($past(shd_reg)))
        else $error("gate readback");
    a_srst_read: assert property (reg_rd && reg_addr == 12'h040 |=> reg_rdata ==
        {15'h0, $past(conv_reset), 12'h0, $past(watchdog_reset_ctrl), 3'h0})
        else $error("reset readback");
    a_srst_write: assert property (srst_hit |=>
        {conv_reset, watchdog_reset_ctrl} == $past(srst_exp))
        else $error("reset write");
    a_srst_hold: assert property (rst_n && !srst_hit |=>
        $stable(conv_reset) && $stable(watchdog_reset_ctrl))
        else $error("reset moved");
    a_unmapped_zero: assert property (reg_rd && reg_addr != 12'h040 && reg_addr != 12'h128
        |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read");
endmodule : dsg_ctrl_chk
bind dsg_ctrl dsg_ctrl_chk #(.NUM_PORTS(NUM_PORTS)) chk_u (.clock, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_state, .auto_clock_gating,
    .run_port_clock_gate, .sleep_port_clock_gate, .capability_mask_first, .port_access,
    .port_clk_en, .port_bus_fault, .conv_reset, .watchdog_reset_ctrl);

// ---- dv/dsg_ctrl_tb.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t %h %h", $time, (g), (e)); end end
module deep_sleep_gating_and_soft_reset_tb;
    logic        clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        auto_clock_gating = 1'b0, conv_reset, watchdog_reset_ctrl;
    logic [1:0]  power_state = 2'h0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, capability_mask_first = 32'hFFFF_FFFF, reg_rdata, v;
    logic [4:0]  run_port_clock_gate = 5'h15, sleep_port_clock_gate = 5'h11;
    logic [4:0]  port_access = 5'h1F, port_clk_en, port_bus_fault;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    dsg_ctrl dut_u (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .power_state, .auto_clock_gating, .run_port_clock_gate, .sleep_port_clock_gate,
        .capability_mask_first, .port_access, .port_clk_en, .port_bus_fault, .conv_reset,
        .watchdog_reset_ctrl);
    initial forever #2.5 clock = ~clock;
    // hang guard, run needs ~60 cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // one strobe cycle; read data caught in the slot after
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= !w;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : bus
    // set state, then enables and faults
    task automatic mode(input logic [1:0] ps, input logic ag, input logic [4:0] pa,
                        input logic [4:0] en);
        @(posedge clock);
        power_state       <= ps;
        auto_clock_gating <= ag;
        port_access       <= pa;
        repeat (2) @(posedge clock);
        #1;
        `CHK(port_clk_en, en)
        `CHK(port_bus_fault, pa & ~en)
    endtask : mode
    task automatic t_regs();
        bus(1'b0, 12'h128, 32'h0);
        `CHK(v, 32'h0000_0000)
        bus(1'b0, 12'h040, 32'h0);
        `CHK(v, 32'h0000_0000)
        bus(1'b1, 12'h128, 32'hFFFF_FFFF);
        bus(1'b0, 12'h128, 32'h0);
        `CHK(v, 32'h0000_001F)
        bus(1'b1, 12'h128, v & 32'hFFFF_FFEA);
        bus(1'b0, 12'h128, 32'h0);
        `CHK(v, 32'h0000_000A)
        $display("regs done");
    endtask : t_regs
    task automatic t_modes();
        mode(2'h2, 1'b1, 5'h1F, 5'h0A);
        mode(2'h1, 1'b1, 5'h1F, 5'h11);
        mode(2'h0, 1'b1, 5'h0F, 5'h15);
        mode(2'h3, 1'b1, 5'h0A, 5'h15);
        mode(2'h2, 1'b0, 5'h1F, 5'h15);
        mode(2'h1, 1'b0, 5'h03, 5'h15);
        $display("modes done");
    endtask : t_modes
    task automatic t_srst();
        bus(1'b1, 12'h040, 32'hFFFF_FFFF);
        bus(1'b0, 12'h040, 32'h0);
        `CHK(v, 32'h0001_0008)
        `CHK({conv_reset, watchdog_reset_ctrl}, 2'h3)
        @(posedge clock);
        capability_mask_first <= 32'hFFFE_FFFF;
        bus(1'b1, 12'h040, 32'h0);
        bus(1'b0, 12'h040, 32'h0);
        `CHK(v, 32'h0001_0000)
        `CHK({conv_reset, watchdog_reset_ctrl}, 2'h2)
        @(posedge clock);
        capability_mask_first <= 32'hFFFF_FFFF;
        bus(1'b1, 12'h040, 32'h0);
        bus(1'b0, 12'h040, 32'h0);
        `CHK(v, 32'h0000_0000)
        `CHK({conv_reset, watchdog_reset_ctrl}, 2'h0)
        $display("srst done");
    endtask : t_srst
    // mid-run reset clears both registers and the unit resets
    task automatic t_rst();
        bus(1'b1, 12'h040, 32'h0001_0008);
        bus(1'b1, 12'h128, 32'h0000_001F);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        `CHK({conv_reset, watchdog_reset_ctrl}, 2'h0)
        bus(1'b0, 12'h128, 32'h0);
        `CHK(v, 32'h0000_0000)
        bus(1'b0, 12'h040, 32'h0);
        `CHK(v, 32'h0000_0000)
        $display("reset done");
    endtask : t_rst
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_modes();
        t_srst();
        t_rst();
        summarize();
    end
endmodule : deep_sleep_gating_and_soft_reset_tb
